// ==== logic/fbsm_pkg.sv ====
/*
  Shared constants and types of the fieldbus slave state machine.
  Assumes a 125 MHz core clock.
*/
package fbsm_pkg;
  // communication states, lowest first; order is used for comparisons
  typedef enum logic [1:0] {
    COMM_INIT,
    COMM_PREOP,
    COMM_SAFEOP,
    COMM_OP
  } fbsm_comm_type;

  // phases of one free-run processing cycle
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_CHECK,
    PH_READ,
    PH_WRITE
  } fbsm_phase_type;

  localparam int AXES = 4;
  localparam int DIN = 8;
  localparam int CLK_PERIOD_NS = 8;
  localparam int CYCLE_NS = 1000;
  localparam int CYCLE_CNT = (CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_W = 7;
  localparam logic [CYC_W-1:0] CYC_LAST = 7'(CYCLE_CNT - 1);
  localparam logic [15:0] NV_IDX_FIRST = 16'h8000;
  localparam logic [15:0] NV_IDX_LAST = 16'h8321;
  localparam logic [15:0] WD_CNT_RESET = 16'h0000;
  localparam logic [CYC_W-1:0] CYC_RESET = 7'h00;
endpackage

// ==== logic/fbsm_di_if.sv ====
/*
  Carrier between the digital-input stage and the slave core.
  Assumes both ends run on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
interface fbsm_di_if;
  logic [7:0] level;
  logic [7:0] limitHit;
  logic [7:0] latchPulse;
  logic [7:0] limitEn;
  logic [7:0] latchEn;
  modport din (input limitEn, input latchEn,
               output level, output limitHit, output latchPulse);
  modport core (output limitEn, output latchEn,
                input level, input limitHit, input latchPulse);
endinterface
`default_nettype wire

// ==== logic/fbsm_din.sv ====
/*
  Eight right/left digital inputs: synchroniser, limit and latch use.
  Assumes diPin is asynchronous to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module fbsm_din (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // pins, bit 2k right and 2k+1 left of axis k
  input wire logic [7:0] diPin,
  // core side
  fbsm_di_if.din di
);
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] prev;
  } fbsm_din_st_type;

  fbsm_din_st_type st_r;
  fbsm_din_st_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = diPin;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign di.level = st_r.sync2;
  // limit and latch may be enabled together on one input
  for (genvar i = 0; i < 8; i++) begin : g_in
    assign di.limitHit[i] = st_r.sync2[i] & di.limitEn[i];
    assign di.latchPulse[i] = st_r.sync2[i] & ~st_r.prev[i]
      & di.latchEn[i];
  end
endmodule
`default_nettype wire

// ==== logic/fbsm_slave.sv ====
/*
  Slave communication state machine with free-run process-data cycle,
  output watchdog and digital-input limit/latch handling.
  Assumes all inputs except diPin come from logic on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module fbsm_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // state control from the master
  input wire fbsm_pkg::fbsm_comm_type stateReq,
  output fbsm_pkg::fbsm_comm_type stateAck,
  output logic errInd,
  output logic internalErrSeen,
  input wire logic internalErr,
  // object store
  output logic nvLoadReq,
  input wire logic nvLoadDone,
  input wire logic nvLoadValid,
  output logic useDefaults,
  input wire logic nvSaveReq,
  input wire logic [15:0] nvSaveIdx,
  output logic nvSaveStart,
  output logic nvSaveNak,
  // mailbox
  input wire logic mbxReq,
  output logic mbxAck,
  output logic mbxNak,
  // output process data from controller memory
  input wire logic pdOutValid,
  input wire logic [31:0] pdOutCmd,
  input wire logic [7:0] pdOutCurrent,
  input wire logic [1:0] pdOutDout,
  output logic pdNak,
  // watchdog and safe values
  input wire logic wdEnable,
  input wire logic [15:0] wdLimit,
  input wire logic [7:0] safeCurrent,
  input wire logic [1:0] safeDout,
  // motion engine
  output logic [31:0] motionCmd,
  output logic motionStrobe,
  output logic [3:0] motorRun,
  output logic [7:0] motorCurrent,
  input wire logic [3:0][31:0] encCount,
  input wire logic [7:0] motionStat,
  // general outputs
  output logic [1:0] gdoOut,
  // digital inputs
  input wire logic [7:0] diPin,
  input wire logic [7:0] limitEn,
  input wire logic [7:0] latchEn,
  input wire logic [7:0] latchClr,
  input wire logic [2:0] latchSel,
  // status written to controller memory
  output logic statusWr,
  output logic [7:0] statusDi,
  output logic [3:0] statusLimit,
  output logic [7:0] statusMotion,
  output logic [3:0][31:0] statusEnc,
  output logic [7:0] statusLatchFlags,
  output logic [31:0] statusLatchPos
);
  typedef struct packed {
    fbsm_pkg::fbsm_comm_type comm;
    fbsm_pkg::fbsm_phase_type phase;
    fbsm_pkg::fbsm_comm_type reqPrev;
    logic errInd;
    logic errSeen;
    logic fallHold;
    logic loadBusy;
    logic loadDone;
    logic useDefaults;
    logic frameSeen;
    logic pdPending;
    logic [31:0] pdCmd;
    logic [7:0] pdCur;
    logic [1:0] pdDout;
    logic [15:0] wdCnt;
    logic [fbsm_pkg::CYC_W-1:0] cyc;
    logic [31:0] motionCmd;
    logic motionStrobe;
    logic [3:0] motorRun;
    logic [7:0] motorCurrent;
    logic [1:0] general_output_channel;
    logic nvLoadReq;
    logic nvSaveStart;
    logic nvSaveNak;
    logic mbxAck;
    logic mbxNak;
    logic pdNak;
    logic statusWr;
    logic [7:0] statusDi;
    logic [3:0] statusLimit;
    logic [7:0] statusMotion;
    logic [3:0][31:0] statusEnc;
    logic [7:0] latchFlags;
    logic [7:0][31:0] latchPos;
    logic [31:0] statusLatchPos;
  } fbsm_st_type;

  fbsm_st_type st_r;
  fbsm_st_type st_nxt;
  fbsm_di_if di ();
  logic [3:0] axisLimit;
  logic wdExpire;

  fbsm_din u_din (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .diPin(diPin),
    .di(di)
  );

  assign di.limitEn = limitEn;
  assign di.latchEn = latchEn;
  for (genvar a = 0; a < 4; a++) begin : g_axis
    assign axisLimit[a] = di.limitHit[2*a] | di.limitHit[2*a+1];
  end
  assign wdExpire = (st_r.comm == fbsm_pkg::COMM_OP) && wdEnable
    && (st_r.wdCnt >= wdLimit) && !pdOutValid;

  always_comb begin
    st_nxt = st_r;
    st_nxt.motionStrobe = 1'b0;
    st_nxt.nvLoadReq = 1'b0;
    st_nxt.nvSaveStart = 1'b0;
    st_nxt.nvSaveNak = 1'b0;
    st_nxt.mbxAck = 1'b0;
    st_nxt.mbxNak = 1'b0;
    st_nxt.pdNak = 1'b0;
    st_nxt.statusWr = 1'b0;
    st_nxt.reqPrev = stateReq;

    // a new request releases a fallback hold
    if (st_r.fallHold && stateReq != st_r.reqPrev) begin
      st_nxt.fallHold = 1'b0;
      st_nxt.errInd = 1'b0;
    end
    if (internalErr) begin
      st_nxt.errSeen = 1'b1;
      st_nxt.errInd = 1'b1;
      st_nxt.fallHold = 1'b1;
      case (st_r.comm)
        fbsm_pkg::COMM_OP: st_nxt.comm = fbsm_pkg::COMM_SAFEOP;
        fbsm_pkg::COMM_SAFEOP: st_nxt.comm = fbsm_pkg::COMM_PREOP;
        default: st_nxt.comm = fbsm_pkg::COMM_INIT;
      endcase
    end else if (wdExpire) begin
      st_nxt.comm = fbsm_pkg::COMM_SAFEOP;
      st_nxt.errInd = 1'b1;
      st_nxt.fallHold = 1'b1;
    end else if (!st_r.fallHold && stateReq != st_r.comm) begin
      if (stateReq < st_r.comm) begin
        st_nxt.comm = stateReq;
      end else begin
        case (st_r.comm)
          fbsm_pkg::COMM_INIT: begin
            if (st_r.loadDone) begin
              st_nxt.comm = fbsm_pkg::COMM_PREOP;
            end
          end
          fbsm_pkg::COMM_PREOP: st_nxt.comm = fbsm_pkg::COMM_SAFEOP;
          fbsm_pkg::COMM_SAFEOP: begin
            if (st_r.frameSeen) begin
              st_nxt.comm = fbsm_pkg::COMM_OP;
            end
          end
          default: st_nxt.comm = st_r.comm;
        endcase
      end
    end

    // object data load on every entry to init
    if (st_r.comm != fbsm_pkg::COMM_INIT) begin
      st_nxt.loadDone = 1'b0;
    end else if (!st_r.loadDone && !st_r.loadBusy) begin
      st_nxt.nvLoadReq = 1'b1;
      st_nxt.loadBusy = 1'b1;
    end else if (st_r.loadBusy && nvLoadDone) begin
      st_nxt.loadBusy = 1'b0;
      st_nxt.loadDone = 1'b1;
      st_nxt.useDefaults = ~nvLoadValid;
    end

    if (nvSaveReq) begin
      if (st_r.comm == fbsm_pkg::COMM_PREOP
          && nvSaveIdx >= fbsm_pkg::NV_IDX_FIRST
          && nvSaveIdx <= fbsm_pkg::NV_IDX_LAST) begin
        st_nxt.nvSaveStart = 1'b1;
      end else begin
        st_nxt.nvSaveNak = 1'b1;
      end
    end

    if (mbxReq) begin
      st_nxt.mbxAck = st_r.comm != fbsm_pkg::COMM_INIT;
      st_nxt.mbxNak = st_r.comm == fbsm_pkg::COMM_INIT;
    end

    if (st_r.comm == fbsm_pkg::COMM_OP && wdEnable && !pdOutValid) begin
      if (st_r.wdCnt != 16'hFFFF) begin
        st_nxt.wdCnt = st_r.wdCnt + 16'h0001;
      end
    end else begin
      st_nxt.wdCnt = fbsm_pkg::WD_CNT_RESET;
    end

    // free-running local cycle
    st_nxt.cyc = (st_r.cyc == fbsm_pkg::CYC_LAST) ? fbsm_pkg::CYC_RESET
      : st_r.cyc + 7'h01;
    case (st_r.phase)
      fbsm_pkg::PH_IDLE: begin
        if (st_r.cyc == fbsm_pkg::CYC_RESET) begin
          st_nxt.phase = fbsm_pkg::PH_CHECK;
        end
      end
      fbsm_pkg::PH_CHECK: begin
        if (st_r.pdPending && st_r.comm == fbsm_pkg::COMM_OP) begin
          st_nxt.motionCmd = st_r.pdCmd;
          st_nxt.motionStrobe = 1'b1;
          st_nxt.motorRun = 4'hF;
          st_nxt.motorCurrent = st_r.pdCur;
          st_nxt.general_output_channel = st_r.pdDout;
        end
        st_nxt.pdPending = 1'b0;
        st_nxt.phase = fbsm_pkg::PH_READ;
      end
      fbsm_pkg::PH_READ: begin
        st_nxt.statusDi = di.level;
        st_nxt.statusLimit = axisLimit;
        st_nxt.statusMotion = motionStat;
        st_nxt.statusEnc = encCount;
        st_nxt.statusLatchPos = st_r.latchPos[latchSel];
        st_nxt.phase = fbsm_pkg::PH_WRITE;
      end
      fbsm_pkg::PH_WRITE: begin
        // status goes out only once inputs are exchanged
        st_nxt.statusWr = st_r.comm >= fbsm_pkg::COMM_SAFEOP;
        st_nxt.phase = fbsm_pkg::PH_IDLE;
      end
      default: st_nxt.phase = fbsm_pkg::PH_IDLE;
    endcase

    // new output data; set wins over the cycle's clear
    if (pdOutValid) begin
      if (st_r.comm >= fbsm_pkg::COMM_SAFEOP) begin
        st_nxt.pdPending = 1'b1;
        st_nxt.pdCmd = pdOutCmd;
        st_nxt.pdCur = pdOutCurrent;
        st_nxt.pdDout = pdOutDout;
        st_nxt.frameSeen = 1'b1;
      end else begin
        st_nxt.pdNak = 1'b1;
      end
    end
    if (st_r.comm < fbsm_pkg::COMM_SAFEOP) begin
      st_nxt.frameSeen = 1'b0;
    end

    // safe outputs in every state but operational
    if (st_nxt.comm != fbsm_pkg::COMM_OP) begin
      st_nxt.motorRun = 4'h0;
      st_nxt.motorCurrent = safeCurrent;
      st_nxt.general_output_channel = safeDout;
    end
    st_nxt.motorRun = st_nxt.motorRun & ~axisLimit;

    for (int i = 0; i < 8; i++) begin
      if (latchClr[i]) begin
        st_nxt.latchFlags[i] = 1'b0;
      end
      if (di.latchPulse[i]) begin
        st_nxt.latchFlags[i] = 1'b1;
        st_nxt.latchPos[i] = encCount[i/2];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.comm <= fbsm_pkg::COMM_INIT;
      st_r.reqPrev <= fbsm_pkg::COMM_INIT;
      st_r.phase <= fbsm_pkg::PH_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stateAck = st_r.comm;
  assign errInd = st_r.errInd;
  assign internalErrSeen = st_r.errSeen;
  assign nvLoadReq = st_r.nvLoadReq;
  assign useDefaults = st_r.useDefaults;
  assign nvSaveStart = st_r.nvSaveStart;
  assign nvSaveNak = st_r.nvSaveNak;
  assign mbxAck = st_r.mbxAck;
  assign mbxNak = st_r.mbxNak;
  assign pdNak = st_r.pdNak;
  assign motionCmd = st_r.motionCmd;
  assign motionStrobe = st_r.motionStrobe;
  assign motorRun = st_r.motorRun;
  assign motorCurrent = st_r.motorCurrent;
  assign gdoOut = st_r.general_output_channel;
  assign statusWr = st_r.statusWr;
  assign statusDi = st_r.statusDi;
  assign statusLimit = st_r.statusLimit;
  assign statusMotion = st_r.statusMotion;
  assign statusEnc = st_r.statusEnc;
  assign statusLatchFlags = st_r.latchFlags;
  assign statusLatchPos = st_r.statusLatchPos;
endmodule
`default_nettype wire

// ==== sim/fbsm_slave_monitor.sv ====
/* Port checker of the slave state machine.
   Assumes one core_clk domain; bound to fbsm_slave. */
`timescale 1ns/1ns
`default_nettype none
module fbsm_slave_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // state
  input wire fbsm_pkg::fbsm_comm_type stateReq,
  input wire fbsm_pkg::fbsm_comm_type stateAck,
  input wire logic errInd,
  input wire logic internalErr,
  // requests and answers
  input wire logic mbxReq,
  input wire logic mbxAck,
  input wire logic mbxNak,
  input wire logic nvSaveReq,
  input wire logic [15:0] nvSaveIdx,
  input wire logic nvSaveStart,
  // outputs
  input wire logic [7:0] safeCurrent,
  input wire logic [1:0] safeDout,
  input wire logic [3:0] motorRun,
  input wire logic [7:0] motorCurrent,
  input wire logic [1:0] gdoOut,
  input wire logic motionStrobe,
  input wire logic statusWr
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_mbx;
    mbxReq |=> mbxNak == !mbxAck &&
      mbxAck == ($past(stateAck) != fbsm_pkg::COMM_INIT);
  endproperty
  a_mbx: assert property (p_mbx) else $error("mailbox answer wrong");
  property p_save;
    nvSaveReq |=> nvSaveStart == ($past(stateAck) == fbsm_pkg::COMM_PREOP &&
      $past(nvSaveIdx) >= 16'h8000 && $past(nvSaveIdx) <= 16'h8321);
  endproperty
  a_save: assert property (p_save) else $error("save answer wrong");
  property p_run;
    stateAck != fbsm_pkg::COMM_OP |-> motorRun == 4'h0;
  endproperty
  a_run: assert property (p_run) else $error("motor runs outside op");
  property p_safe;
    $past(stateAck) == fbsm_pkg::COMM_OP && stateAck != fbsm_pkg::COMM_OP |->
      motorCurrent == $past(safeCurrent) && gdoOut == $past(safeDout);
  endproperty
  a_safe: assert property (p_safe) else $error("outputs not safe");
  property p_strobe;
    motionStrobe |-> $past(stateAck) == fbsm_pkg::COMM_OP;
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("strobe outside op");
  property p_wr;
    statusWr |-> $past(stateAck) >= fbsm_pkg::COMM_SAFEOP;
  endproperty
  a_wr: assert property (p_wr) else $error("status write too early");
  property p_err;
    internalErr && stateAck == fbsm_pkg::COMM_OP |=>
      stateAck == fbsm_pkg::COMM_SAFEOP && errInd;
  endproperty
  a_err: assert property (p_err) else $error("no drop on error");
  property p_hold;
    errInd && !internalErr && $stable(stateReq) |=> $stable(stateAck);
  endproperty
  a_hold: assert property (p_hold) else $error("left held state");
  c_op: cover property (stateAck == fbsm_pkg::COMM_OP);
  c_err: cover property ($rose(errInd));
  c_save: cover property (nvSaveStart);
endmodule
bind fbsm_slave fbsm_slave_monitor mon_u (.core_clk, .arst_n, .stateReq,
  .stateAck, .errInd, .internalErr, .mbxReq, .mbxAck, .mbxNak, .nvSaveReq,
  .nvSaveIdx, .nvSaveStart, .safeCurrent, .safeDout, .motorRun,
  .motorCurrent, .gdoOut, .motionStrobe, .statusWr);
`default_nettype wire

// ==== sim/fbsm_master_model.sv ====
/* Master model: requests states, sends cyclic output data.
   Assumes the bench sets goal state and data period. */
`timescale 1ns/1ns
`default_nettype none
module fbsm_master_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // bench control, period 0 stops the data
  input wire fbsm_pkg::fbsm_comm_type goal,
  input wire logic [7:0] period,
  input wire logic [31:0] cmd,
  input wire logic [7:0] cur,
  input wire logic [1:0] dout,
  // slave side
  output fbsm_pkg::fbsm_comm_type stateReq,
  output logic pdOutValid,
  output logic [31:0] pdOutCmd,
  output logic [7:0] pdOutCurrent,
  output logic [1:0] pdOutDout
);
  logic [7:0] cnt_r;
  logic fire;
  assign fire = period != 8'h00 && cnt_r == 8'h00;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= 8'h00;
      stateReq <= fbsm_pkg::COMM_INIT;
      pdOutValid <= 1'b0;
      pdOutCmd <= 32'h0;
      pdOutCurrent <= 8'h00;
      pdOutDout <= 2'h0;
    end else begin
      cnt_r <= cnt_r >= period ? 8'h00 : cnt_r + 8'h01;
      stateReq <= goal;
      pdOutValid <= fire;
      // data is only valid with the pulse, so show junk between
      pdOutCmd <= fire ? cmd : ~cmd;
      pdOutCurrent <= fire ? cur : ~cur;
      pdOutDout <= fire ? dout : ~dout;
    end
  end
endmodule
`default_nettype wire

// ==== sim/test_fbsm_slave.sv ====
/* Self-checking bench of fbsm_slave with the master model.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ns
`default_nettype none
module test_fbsm_slave;
  logic core_clk, arst_n, internalErr, nvLoadDone, nvLoadValid, nvSaveReq;
  logic mbxReq, mbxAck, mbxNak, wdEnable, errInd, internalErrSeen;
  logic nvLoadReq, useDefaults, nvSaveStart, nvSaveNak, pdOutValid;
  logic motionStrobe, statusWr, pdNak;
  logic [15:0] nvSaveIdx, wdLimit;
  logic [31:0] pdOutCmd, cmd, motionCmd, statusLatchPos;
  logic [7:0] pdOutCurrent, cur, safeCurrent, motorCurrent, motionStat;
  logic [7:0] period, statusMotion, statusLatchFlags, statusDi;
  logic [7:0] diPin, limitEn, latchEn, latchClr;
  logic [1:0] pdOutDout, dout, safeDout, gdoOut;
  logic [2:0] latchSel;
  logic [3:0] motorRun, statusLimit;
  logic [3:0][31:0] encCount, statusEnc;
  fbsm_pkg::fbsm_comm_type stateReq, stateAck, goal;
  int errors, comparisons, cycles, n1, n2;
  fbsm_master_model master_u (.core_clk, .arst_n, .goal, .period, .cmd,
    .cur, .dout, .stateReq, .pdOutValid, .pdOutCmd, .pdOutCurrent,
    .pdOutDout);
  fbsm_slave dut_u (.core_clk, .arst_n, .stateReq, .stateAck, .errInd,
    .internalErrSeen, .internalErr, .nvLoadReq, .nvLoadDone, .nvLoadValid,
    .useDefaults, .nvSaveReq, .nvSaveIdx, .nvSaveStart, .nvSaveNak, .mbxReq,
    .mbxAck, .mbxNak, .pdOutValid, .pdOutCmd, .pdOutCurrent, .pdOutDout,
    .pdNak, .wdEnable, .wdLimit, .safeCurrent, .safeDout, .motionCmd,
    .motionStrobe, .motorRun, .motorCurrent, .encCount, .motionStat,
    .gdoOut, .diPin, .limitEn, .latchEn, .latchClr, .latchSel, .statusWr,
    .statusDi, .statusLimit, .statusMotion, .statusEnc,
    .statusLatchFlags, .statusLatchPos);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic mbx(input logic ack);
    @(posedge core_clk) mbxReq <= 1'b1;
    @(posedge core_clk) mbxReq <= 1'b0;
    @(negedge core_clk);
    chk({mbxAck, mbxNak}, {ack, !ack});
  endtask
  task automatic save(input logic [15:0] idx, input logic ok);
    @(posedge core_clk) nvSaveReq <= 1'b1;
    nvSaveIdx <= idx;
    @(posedge core_clk) nvSaveReq <= 1'b0;
    @(negedge core_clk);
    chk({nvSaveStart, nvSaveNak}, {ok, !ok});
  endtask
  task automatic goTo(input fbsm_pkg::fbsm_comm_type s);
    @(posedge core_clk) goal <= s;
    for (int i = 0; i < 200 && stateAck !== s; i++) @(negedge core_clk);
    chk(stateAck, s);
  endtask
  task automatic waitStrobe();
    repeat (4) @(negedge core_clk);
    for (int i = 0; i < 300 && motionStrobe !== 1'b1; i++)
      @(negedge core_clk);
  endtask
  task automatic t_init();
    @(negedge core_clk);
    chk(stateAck, fbsm_pkg::COMM_INIT);
    mbx(1'b0);
    save(16'h8000, 1'b0);
    chk(useDefaults, 1'b1);
    goTo(fbsm_pkg::COMM_PREOP);
    mbx(1'b1);
    save(16'h7FFF, 1'b0);
    save(16'h8000, 1'b1);
    save(16'h8321, 1'b1);
    save(16'h8322, 1'b0);
    @(posedge core_clk) period <= 8'h0A;
    for (int i = 0; i < 20 && pdOutValid !== 1'b1; i++) @(negedge core_clk);
    @(negedge core_clk);
    chk(pdNak, 1'b1);
    $display("test init and preop done");
  endtask
  task automatic t_run();
    @(posedge core_clk) period <= 8'h0A;
    goTo(fbsm_pkg::COMM_OP);
    waitStrobe();
    chk({motionCmd, motorCurrent}, {32'hC0DE1234, 8'h3C});
    chk(gdoOut, 2'h2);
    chk(motorRun, 4'hF);
    n1 = 0;
    do begin
      @(negedge core_clk);
      n1++;
    end while (motionStrobe !== 1'b1 && n1 < 300);
    chk(n1, fbsm_pkg::CYCLE_CNT);
    for (int i = 0; i < 10 && statusWr !== 1'b1; i++) @(negedge core_clk);
    chk({statusEnc[3], statusMotion}, {32'h000000A3, 8'h5A});
    @(posedge core_clk) limitEn <= 8'h04;
    diPin <= 8'h04;
    latchEn <= 8'h80;
    waitStrobe();
    chk(motorRun, 4'hD);
    for (int i = 0; i < 10 && statusWr !== 1'b1; i++) @(negedge core_clk);
    chk({statusDi, statusLimit}, {8'h04, 4'h2});
    @(posedge core_clk) diPin <= 8'h84;
    repeat (5) @(negedge core_clk);
    chk(statusLatchFlags[7], 1'b1);
    @(posedge core_clk) latchClr <= 8'h80;
    latchSel <= 3'h7;
    @(posedge core_clk) latchClr <= 8'h00;
    repeat (3) @(negedge core_clk);
    for (int i = 0; i < 200 && statusWr !== 1'b1; i++) @(negedge core_clk);
    chk({statusLatchFlags[7], statusLatchPos}, {1'b0, 32'h000000A3});
    @(posedge core_clk) diPin <= 8'h00;
    $display("test free-run done");
  endtask
  task automatic t_wd();
    @(posedge core_clk) period <= 8'h00;
    for (int i = 0; i < 200 && stateAck === fbsm_pkg::COMM_OP; i++)
      @(negedge core_clk);
    chk({stateAck, errInd}, {fbsm_pkg::COMM_SAFEOP, 1'b1});
    chk({motorRun, motorCurrent, gdoOut}, {4'h0, 8'h11, 2'h1});
    @(posedge core_clk) period <= 8'h0A;
    n1 = 0;
    n2 = 0;
    repeat (300) begin
      @(negedge core_clk);
      n1 += motionStrobe;
      n2 += statusWr;
    end
    chk(n1, 0);
    chk(n2 != 0, 1'b1);
    chk(stateAck, fbsm_pkg::COMM_SAFEOP);
    @(posedge core_clk) goal <= fbsm_pkg::COMM_SAFEOP;
    repeat (3) @(posedge core_clk);
    goTo(fbsm_pkg::COMM_OP);
    chk(errInd, 1'b0);
    $display("test watchdog done");
  endtask
  task automatic t_err();
    @(posedge core_clk) internalErr <= 1'b1;
    @(posedge core_clk) internalErr <= 1'b0;
    @(negedge core_clk);
    chk({stateAck, errInd}, {fbsm_pkg::COMM_SAFEOP, 1'b1});
    chk(internalErrSeen, 1'b1);
    $display("test internal error done");
  endtask
  task automatic t_reset();
    @(posedge core_clk) arst_n <= 1'b0;
    nvLoadValid <= 1'b1;
    goal <= fbsm_pkg::COMM_INIT;
    period <= 8'h00;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(negedge core_clk);
    chk(stateAck, fbsm_pkg::COMM_INIT);
    chk({errInd, internalErrSeen, motorRun}, 6'h00);
    repeat (4) @(negedge core_clk);
    chk(useDefaults, 1'b0);
    $display("test reset done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    nvLoadDone <= nvLoadReq;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    {arst_n, internalErr, nvLoadDone, nvLoadValid, nvSaveReq, mbxReq} = '0;
    {nvSaveIdx, diPin, limitEn, latchEn, latchClr, latchSel, period} = '0;
    {errors, comparisons, cycles} = '0;
    goal = fbsm_pkg::COMM_INIT;
    {wdEnable, wdLimit, safeCurrent, safeDout} = {1'b1, 16'h0028, 8'h11, 2'h1};
    {cmd, cur, dout, motionStat} = {32'hC0DE1234, 8'h3C, 2'h2, 8'h5A};
    encCount = {32'hA3, 32'hA2, 32'hA1, 32'hA0};
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_init();
    t_run();
    t_wd();
    t_err();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
